/* File: design/uart_chan.v */
`timescale 1ns/100ps
`include "uart_chan_consts.vh"

module uart_chan #(
   parameter [2:0] CHANNEL = 3'h0
) (
   input  wire        sys_clk,     // 200 MHz clock
   input  wire        rst_n,       // Async reset, active low
   input  wire        bus_sel,     // Access strobe, one cycle
   input  wire        bus_wr,      // 1 write, 0 read
   input  wire [11:0] bus_addr,    // Channel and register address
   input  wire [7:0]  bus_wdata,   // Write data
   output reg  [7:0]  bus_rdata_q, // Read data
   output reg         bus_ack_q,   // Access taken by this channel
   input  wire        ir_en_pin,   // Global infrared start-up enable
   input  wire        rx_pin,      // Serial receive pin
   output reg         tx_pin_q,    // Serial transmit pin
   input  wire        cts_n_pin,   // Clear to send, active low
   input  wire        dsr_n_pin,   // Data set ready, active low
   input  wire        cd_n_pin,    // Carrier detect, active low
   input  wire        ri_n_pin,    // Ring indicator, active low
   output reg         rts_n_q,     // Request to send, active low
   output reg         dtr_n_q      // Data terminal ready, active low
);

   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_START = 2'h1;
   localparam [1:0] S_DATA = 2'h2;
   localparam [1:0] S_STOP = 2'h3;

   // ****************************************
   // Register storage
   // ****************************************
   reg [7:0]  ier_q, lcr_q, mcr_q, spr_q, feature_control_q, efr_q;
   reg [7:0]  dll_q, dlm_q, dld_q, delay_q, fcr_q;
   reg [7:0]  tx_fifo_trigger_q, rx_fifo_trigger_q;
   reg [7:0]  xchar_q [0:3];
   reg [7:0]  thr_q, rhr_q;
   reg        thr_full_q, rhr_full_q, overrun_q, frame_q;
   reg [3:0]  msr_delta_q;
   reg [1:0]  init_q;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg [5:0] s1_q, s2_q;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 6'h3f;
         s2_q <= 6'h3f;
      end else begin
         s1_q <= {ir_en_pin, rx_pin, cts_n_pin, dsr_n_pin, cd_n_pin,
                  ri_n_pin};
         s2_q <= s1_q;
      end
   end
   wire ir_en_s = s2_q[5];
   wire rx_s    = s2_q[4];

   wire loop_on = mcr_q[`MCR_LOOP];
   wire ir_on   = mcr_q[`MCR_IR];

   // Modem inputs; loopback feeds them from control bits instead of pins
   wire [3:0] mpin = {~s2_q[1], ~s2_q[0], ~s2_q[2], ~s2_q[3]};
   wire [3:0] mloop = {mcr_q[3], mcr_q[2], mcr_q[`MCR_DTR],
                       mcr_q[`MCR_RTS]};
   wire [3:0] mstat = loop_on ? mloop : mpin; // {cd,ri,dsr,cts}
   reg  [3:0] mstat_q;

   // ****************************************
   // Address decode
   // ****************************************
   wire       hit  = bus_sel && (bus_addr[11:9] == CHANNEL);
   wire [3:0] ofs  = bus_addr[3:0];
   wire       dlab = lcr_q[`LCR_DLAB];
   wire       wr   = hit && bus_wr;
   wire       rd   = hit && !bus_wr;

   // ****************************************
   // Baud tick: 16x oversampling
   // ****************************************
   reg [15:0] baud_cnt_q;
   wire [15:0] divisor = {dlm_q, dll_q};
   wire tick = (baud_cnt_q == 16'h0000);
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         baud_cnt_q <= 16'h0000;
      else if (tick)
         baud_cnt_q <= (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
      else
         baud_cnt_q <= baud_cnt_q - 16'h0001;
   end

   // ****************************************
   // Transmitter
   // ****************************************
   reg [1:0] tx_st_q;
   reg [3:0] tx_ovs_q;
   reg [2:0] tx_bit_q;
   reg [7:0] tx_sh_q;
   wire cts_block = efr_q[`EFR_ACTS] && !mstat[0];
   wire tx_busy = (tx_st_q != S_IDLE);
   reg tx_line; // Shift register output, before any encoding
   always @* begin
      case (tx_st_q)
         S_START: tx_line = 1'b0;
         S_DATA:  tx_line = tx_sh_q[0];
         default: tx_line = 1'b1;
      endcase
   end

   // A new character starts only between characters, so a flow stop
   // never truncates the one in flight
   wire tx_take = tick && !tx_busy && thr_full_q && !cts_block;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_st_q  <= S_IDLE;
         tx_ovs_q <= 4'h0;
         tx_bit_q <= 3'h0;
         tx_sh_q  <= `RST_BYTE;
      end else if (tx_take) begin
         tx_st_q  <= S_START;
         tx_ovs_q <= 4'h0;
         tx_sh_q  <= thr_q;
      end else if (tick && tx_busy) begin
         tx_ovs_q <= tx_ovs_q + 4'h1;
         if (tx_ovs_q == `OVS_LAST) begin
            case (tx_st_q)
               S_START: begin
                  tx_st_q  <= S_DATA;
                  tx_bit_q <= 3'h0;
               end
               S_DATA: begin
                  tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == 3'h7)
                     tx_st_q <= S_STOP;
               end
               default: tx_st_q <= S_IDLE;
            endcase
         end
      end
   end

   // Encoder: high pulse on samples 6..8, the middle 3/16 of a zero bit
   wire ir_pulse = !tx_line && (tx_ovs_q >= `IR_PULSE_LO)
                   && (tx_ovs_q <= `IR_PULSE_HI);
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         tx_pin_q <= 1'b1;
      else if (loop_on)
         tx_pin_q <= 1'b1;
      else if (ir_on)
         tx_pin_q <= ir_pulse;
      else
         tx_pin_q <= tx_line;
   end

   // ****************************************
   // Receive front end and decoder
   // ****************************************
   wire ir_raw = feature_control_q[`FEATURE_CONTROL_IRINV] ? ~rx_s : rx_s;
   reg [4:0] ir_hold_q;
   // A pulse pulls the decoded line low for one bit time; idle low input
   // therefore decodes as a steady one
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         ir_hold_q <= 5'h00;
      else if (ir_raw)
         ir_hold_q <= `IR_HOLD;
      else if (tick && ir_hold_q != 5'h00)
         ir_hold_q <= ir_hold_q - 5'h01;
   end
   wire ir_line = (ir_hold_q == 5'h00);
   reg rx_line;
   always @* begin
      if (loop_on)
         rx_line = tx_line;
      else if (ir_on)
         rx_line = tx_busy ? 1'b1 : ir_line;
      else
         rx_line = rx_s;
   end

   // ****************************************
   // Receiver
   // ****************************************
   reg [1:0] rx_st_q;
   reg [3:0] rx_ovs_q;
   reg [2:0] rx_bit_q;
   reg [7:0] rx_sh_q;
   reg       rx_done;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_q  <= S_IDLE;
         rx_ovs_q <= 4'h0;
         rx_bit_q <= 3'h0;
         rx_sh_q  <= `RST_BYTE;
         rx_done  <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (tick) begin
            rx_ovs_q <= rx_ovs_q + 4'h1;
            case (rx_st_q)
               S_IDLE: if (!rx_line) begin
                  rx_st_q  <= S_START;
                  rx_ovs_q <= 4'h0;
               end
               S_START: if (rx_ovs_q == `OVS_MID) begin
                  rx_ovs_q <= 4'h0;
                  rx_bit_q <= 3'h0;
                  rx_st_q  <= rx_line ? S_IDLE : S_DATA;
               end
               S_DATA: if (rx_ovs_q == `OVS_LAST) begin
                  rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == 3'h7)
                     rx_st_q <= S_STOP;
               end
               default: if (rx_ovs_q == `OVS_LAST) begin
                  rx_st_q <= S_IDLE;
                  rx_done <= 1'b1;
               end
            endcase
         end
      end
   end
   reg rx_stop_ok_q;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         rx_stop_ok_q <= 1'b1;
      else if (tick && rx_st_q == S_STOP && rx_ovs_q == `OVS_LAST)
         rx_stop_ok_q <= rx_line;
   end

   // ****************************************
   // Register writes and holding flags
   // ****************************************
   wire rd_rhr = rd && !dlab && ofs == `OFS_DATA;
   wire rd_msr = rd && ofs == `OFS_MSR;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ier_q <= `RST_BYTE;  lcr_q <= `RST_BYTE;  mcr_q <= `RST_BYTE;
         spr_q <= `RST_BYTE;  feature_control_q <= `RST_BYTE; efr_q <= `RST_BYTE;
         dll_q <= `RST_DIV;   dlm_q <= `RST_BYTE;  dld_q <= `RST_BYTE;
         delay_q <= `RST_BYTE; fcr_q <= `RST_BYTE;
         tx_fifo_trigger_q <= `RST_BYTE; rx_fifo_trigger_q <= `RST_BYTE;
         xchar_q[0] <= `RST_BYTE; xchar_q[1] <= `RST_BYTE;
         xchar_q[2] <= `RST_BYTE; xchar_q[3] <= `RST_BYTE;
         thr_q <= `RST_BYTE;  thr_full_q <= 1'b0;
         init_q <= 2'h0;
      end else begin
         // Preset waits for the pin to clear its synchroniser
         if (init_q != 2'h3)
            init_q <= init_q + 2'h1;
         if (init_q == 2'h2)
            mcr_q[`MCR_IR] <= ir_en_s;
         if (tx_take)
            thr_full_q <= 1'b0;
         if (wr) begin
            if (ofs == `OFS_DATA) begin
               if (dlab)
                  dll_q <= bus_wdata;
               else begin
                  thr_q      <= bus_wdata;
                  thr_full_q <= 1'b1;
               end
            end else if (ofs == `OFS_IER) begin
               if (dlab)
                  dlm_q <= bus_wdata;
               else
                  ier_q <= bus_wdata;
            end else if (ofs == `OFS_ISR) begin
               if (dlab)
                  dld_q <= {4'h0, bus_wdata[3:0]};
               else
                  fcr_q <= bus_wdata;
            end else if (ofs == `OFS_LCR)
               lcr_q <= bus_wdata;
            else if (ofs == `OFS_MCR)
               mcr_q <= bus_wdata;
            else if (ofs == `OFS_MSR)
               delay_q <= bus_wdata;
            else if (ofs == `OFS_SPR)
               spr_q <= bus_wdata;
            else if (ofs == `OFS_FEATURE_CONTROL)
               feature_control_q <= bus_wdata;
            else if (ofs == `OFS_EFR)
               efr_q <= bus_wdata;
            else if (ofs == `OFS_TX_FIFO_LEVEL)
               tx_fifo_trigger_q <= bus_wdata;
            else if (ofs == `OFS_RX_FIFO_LEVEL)
               rx_fifo_trigger_q <= bus_wdata;
            else if (ofs >= `OFS_XCHAR)
               xchar_q[ofs[1:0]] <= bus_wdata;
         end
      end
   end

   // Receive holding; new data wins over a read in the same cycle
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rhr_q <= `RST_BYTE;
         rhr_full_q <= 1'b0;
         overrun_q <= 1'b0;
         frame_q <= 1'b0;
      end else if (rx_done) begin
         rhr_q <= rx_sh_q;
         rhr_full_q <= 1'b1;
         frame_q <= !rx_stop_ok_q;
         if (rhr_full_q && !rd_rhr)
            overrun_q <= 1'b1;
      end else if (rd_rhr) begin
         rhr_full_q <= 1'b0;
         frame_q <= 1'b0;
      end
   end

   // Modem deltas: sticky, set beats the clearing read
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mstat_q <= 4'h0;
         msr_delta_q <= 4'h0;
      end else begin
         mstat_q <= mstat;
         msr_delta_q <= (rd_msr ? 4'h0 : msr_delta_q) | (mstat ^ mstat_q);
      end
   end

   // ****************************************
   // Flow control outputs
   // ****************************************
   wire [7:0] rx_level = {7'h00, rhr_full_q};
   wire [7:0] tx_level = {7'h00, thr_full_q};
   reg rts_hold_q;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         rts_hold_q <= 1'b0;
      else if (!efr_q[`EFR_ARTS])
         rts_hold_q <= 1'b0;
      else if (rx_level <= {4'h0, feature_control_q[3:0]})
         rts_hold_q <= 1'b0;
      else if (rx_fifo_trigger_q != 8'h00 && rx_level >= rx_fifo_trigger_q)
         rts_hold_q <= 1'b1;
   end
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rts_n_q <= 1'b1;
         dtr_n_q <= 1'b1;
      end else begin
         rts_n_q <= loop_on || !mcr_q[`MCR_RTS] || rts_hold_q;
         dtr_n_q <= loop_on || !mcr_q[`MCR_DTR];
      end
   end

   // ****************************************
   // Register reads
   // ****************************************
   wire [7:0] line_status = {1'b0, !tx_busy && !thr_full_q, !thr_full_q, 1'b0,
                     frame_q, 1'b0, overrun_q, rhr_full_q};
   wire [3:0] isr_src = (ier_q[0] && rhr_full_q) ? 4'h4 :
                        (ier_q[1] && !thr_full_q) ? 4'h2 : 4'h1;
   reg [7:0] rd_mux;
   always @* begin
      if (ofs == `OFS_DATA)
         rd_mux = dlab ? dll_q : rhr_q;
      else if (ofs == `OFS_IER)
         rd_mux = dlab ? dlm_q : ier_q;
      else if (ofs == `OFS_ISR)
         rd_mux = dlab ? dld_q : {{2{fcr_q[0]}}, 2'h0, isr_src};
      else if (ofs == `OFS_LCR)
         rd_mux = lcr_q;
      else if (ofs == `OFS_MCR)
         rd_mux = mcr_q;
      else if (ofs == `OFS_LSR)
         rd_mux = line_status;
      else if (ofs == `OFS_MSR)
         rd_mux = {mstat, msr_delta_q};
      else if (ofs == `OFS_SPR)
         rd_mux = spr_q;
      else if (ofs == `OFS_FEATURE_CONTROL)
         rd_mux = feature_control_q;
      else if (ofs == `OFS_EFR)
         rd_mux = efr_q;
      else if (ofs == `OFS_TX_FIFO_LEVEL)
         rd_mux = tx_level;
      else if (ofs == `OFS_RX_FIFO_LEVEL)
         rd_mux = rx_level;
      else
         rd_mux = 8'h00; // Flow flags idle; 0xc-0xf write-only
   end
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata_q <= 8'h00;
         bus_ack_q <= 1'b0;
      end else begin
         bus_ack_q <= hit;
         bus_rdata_q <= rd ? rd_mux : 8'h00;
      end
   end

endmodule

/* File: design/uart_chan_consts.vh */
`ifndef UART_CHAN_CONSTS_VH
`define UART_CHAN_CONSTS_VH
`define OFS_DATA      4'h0
`define OFS_IER       4'h1
`define OFS_ISR       4'h2
`define OFS_LCR       4'h3
`define OFS_MCR       4'h4
`define OFS_LSR       4'h5
`define OFS_MSR       4'h6
`define OFS_SPR       4'h7
`define OFS_FEATURE_CONTROL      4'h8
`define OFS_EFR       4'h9
`define OFS_TX_FIFO_LEVEL     4'ha
`define OFS_RX_FIFO_LEVEL     4'hb
`define OFS_XCHAR     4'hc
`define OFS_XOFF2     4'hd
`define OFS_XON1      4'he
`define OFS_XON2      4'hf
`define LCR_DLAB      7
`define MCR_DTR       0
`define MCR_RTS       1
`define MCR_LOOP      4
`define MCR_IR        6
`define EFR_ARTS      6
`define EFR_ACTS      7
`define FEATURE_CONTROL_IRINV    4
`define RST_BYTE      8'h00
`define RST_DIV       8'h01
`define OVS_LAST      4'hf
`define OVS_MID       4'h7
`define IR_PULSE_LO   4'h6
`define IR_PULSE_HI   4'h8
`define IR_HOLD       5'h10
`endif

/* File: tb/uart_chan_props.sv */
`timescale 1ns/100ps
// ***************************************
// Register bus and serial pin checker
// ***************************************
module uart_chan_props #(
   parameter [2:0] CHANNEL = 3'h0
) (
   input logic        sys_clk,     // Clock
   input logic        rst_n,       // Async reset, active low
   input logic        bus_sel,     // Access strobe
   input logic        bus_wr,      // Write when high
   input logic [11:0] bus_addr,    // Channel and offset
   input logic [7:0]  bus_wdata,   // Write data
   input logic [7:0]  bus_rdata_q, // Read data
   input logic        bus_ack_q,   // Acknowledge
   input logic        tx_pin_q,    // Serial transmit pin
   input logic        rts_n_q,     // Request to send
   input logic        dtr_n_q      // Data terminal ready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   wire       hit    = bus_sel && (bus_addr[11:9] == CHANNEL);
   wire       rd_hit = hit && !bus_wr;
   wire       wr_hit = hit && bus_wr;
   wire [3:0] ofs    = bus_addr[3:0];
   reg        dlab_q;
   reg        loop_q;
   reg        ir_q;
   reg        irk_q;
   reg [15:0] div_q;
   // Infrared pulse timing is only fixed at divisor 1, so gate on it
   wire       ir_on  = irk_q && ir_q && (div_q == 16'h0001);

   // Shadow of the mode bits; the pin preset is unknown here, so the
   // infrared checks wait for a software write to modem control
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dlab_q <= 1'b0;
         loop_q <= 1'b0;
         ir_q   <= 1'b0;
         irk_q  <= 1'b0;
         div_q  <= 16'h0001;
      end else if (wr_hit) begin
         if (ofs == 4'h3)
            dlab_q <= bus_wdata[7];
         if (ofs == 4'h4) begin
            loop_q <= bus_wdata[4];
            ir_q   <= bus_wdata[6];
            irk_q  <= 1'b1;
         end
         if (dlab_q && ofs == 4'h0)
            div_q[7:0] <= bus_wdata;
         if (dlab_q && ofs == 4'h1)
            div_q[15:8] <= bus_wdata;
      end
   end

   a_ack_hit: assert property (hit |=> bus_ack_q)
      else $error("access to own channel not acknowledged");
   a_ack_miss: assert property (!hit |=> !bus_ack_q)
      else $error("acknowledge without access to own channel");
   a_rdata_idle: assert property (!rd_hit |=> bus_rdata_q == 8'h00)
      else $error("read data not zero without a read");
   a_wronly_zero: assert property (
      rd_hit && ofs[3:2] == 2'b11 |=> bus_rdata_q == 8'h00)
      else $error("write-only character offset returned data");
   a_div_low: assert property (
      rd_hit && dlab_q && ofs == 4'h0 |=> bus_rdata_q == div_q[7:0])
      else $error("divisor low byte read wrong");
   a_div_high: assert property (
      rd_hit && dlab_q && ofs == 4'h1 |=> bus_rdata_q == div_q[15:8])
      else $error("divisor high byte read wrong");
   a_loop_mark: assert property (
      loop_q && $past(loop_q, 2) |-> tx_pin_q)
      else $error("transmit pin left mark in loopback");
   a_loop_ctl: assert property (
      loop_q && $past(loop_q, 2) |-> rts_n_q && dtr_n_q)
      else $error("modem outputs asserted in loopback");
   a_ir_pulse: assert property (
      ir_on && $rose(tx_pin_q) |-> tx_pin_q [*3] ##1 !tx_pin_q)
      else $error("infrared pulse not three ticks wide");
   a_ir_gap: assert property (
      ir_on && $fell(tx_pin_q) |-> !tx_pin_q [*8])
      else $error("infrared output not idling low");

   c_loop: cover property (wr_hit && ofs == 4'h4 && bus_wdata[4]);
   c_ir_pulse: cover property (ir_on && $rose(tx_pin_q));
   c_miss: cover property (bus_sel && !hit);
endmodule

bind uart_chan uart_chan_props #(.CHANNEL(CHANNEL)) u_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .bus_sel(bus_sel), .bus_wr(bus_wr),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
   .bus_ack_q(bus_ack_q), .tx_pin_q(tx_pin_q), .rts_n_q(rts_n_q),
   .dtr_n_q(dtr_n_q)
);

/* File: tb/serial_peer.sv */
`timescale 1ns/100ps
// ***************************
// Line transceiver stand-in
// ***************************
module serial_peer (
   input  logic sys_clk, // Clock shared with the channel
   input  logic tx_line, // Channel transmit pin
   output logic rx_line  // Channel receive pin
);
   initial rx_line = 1'b1;

   // One 8N1 frame at 16 clocks a bit; infrared frames pulse on ticks
   // 6..8 of each zero bit, inverted for active-low modules
   task automatic send(input logic [7:0] b, input logic ir,
                       input logic inv);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         for (int t = 0; t < 16; t++) begin
            @(posedge sys_clk);
            rx_line <= ir ? (!f[i] && t >= 6 && t <= 8) ^ inv
                          : f[i];
         end
      end
      @(posedge sys_clk);
      rx_line <= ir ? inv : 1'b1;
   endtask

   // Bounded wait for a start edge or pulse, then one sample per cell;
   // in infrared mode a pulse decodes as zero
   task automatic recv(input logic ir, output logic [7:0] b);
      int n;
      n = 0;
      while (tx_line !== ir && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      repeat (ir ? 1 : 8) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(posedge sys_clk);
         b[i] = tx_line ^ ir;
      end
   endtask
endmodule

/* File: tb/uart_chan_bench.sv */
`timescale 1ns/100ps
`define CHK(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) begin \
         miscompares++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
      end \
   end
// ************************
// Channel testbench
// ************************
module uart_chan_bench;
   localparam [2:0] CH = 3'h5;
   logic        sys_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic        bus_sel, bus_wr, ir_en_pin, rx_pin, tx_pin_q;
   logic        cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin;
   logic        bus_ack_q, rts_n_q, dtr_n_q;
   logic [11:0] bus_addr;
   logic [7:0]  bus_wdata, bus_rdata_q, got;
   logic [2:0]  ch = CH;
   int          miscompares = 0;
   int          comparisons = 0;
   int          n;

   uart_chan #(.CHANNEL(CH)) u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .bus_sel(bus_sel),
      .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q),
      .ir_en_pin(ir_en_pin), .rx_pin(rx_pin), .tx_pin_q(tx_pin_q),
      .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin), .cd_n_pin(cd_n_pin),
      .ri_n_pin(ri_n_pin), .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q)
   );
   serial_peer u_peer (.sys_clk(sys_clk), .tx_line(tx_pin_q),
                       .rx_line(rx_pin));

   // Free-running 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // One-cycle strobe; the channel answers one edge later
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_sel   <= 1'b1;
      bus_wr    <= 1'b1;
      bus_addr  <= {ch, 5'h00, a};
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_sel   <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      @(posedge sys_clk);
      bus_sel  <= 1'b1;
      bus_wr   <= 1'b0;
      bus_addr <= {ch, 5'h00, a};
      @(posedge sys_clk);
      bus_sel  <= 1'b0;
      #1;
      `CHK(bus_rdata_q & m, e)
   endtask
   task automatic close_out;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Watchdog: the tests need about 7000 cycles, so 20000 is a hang
   initial begin
      #100000;
      miscompares++;
      close_out;
   end

   // Main sequence; divisor stays 1 except while the divisor is probed
   initial begin
      {bus_sel, bus_wr, bus_addr, bus_wdata} = '0;
      {ir_en_pin, cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin} = 5'b10111;
      cyc(10);
      `CHK({tx_pin_q, rts_n_q, dtr_n_q}, 3'b111)
      rst_n <= 1'b1;
      cyc(4);
      rd(4'h4, 8'hff, 8'h40);
      wr(4'h4, 8'h00);
      rd(4'h4, 8'hff, 8'h00);
      wr(4'h7, 8'h3c);
      ch = 3'h2;
      wr(4'h7, 8'hc3);
      rd(4'h7, 8'hff, 8'h00);
      `CHK(bus_ack_q, 1'b0)
      ch = CH;
      rd(4'h7, 8'hff, 8'h3c);
      wr(4'h3, 8'h80);
      rd(4'h0, 8'hff, 8'h01);
      wr(4'h1, 8'h12);
      rd(4'h1, 8'hff, 8'h12);
      wr(4'h2, 8'hab);
      rd(4'h2, 8'hff, 8'h0b);
      wr(4'h1, 8'h00);
      // The probe reloaded the baud counter with a long count; wait it out
      cyc(4700);
      wr(4'h3, 8'h03);
      rd(4'h2, 8'hff, 8'h01);
      wr(4'h2, 8'h01);
      rd(4'h2, 8'hff, 8'hc1);
      wr(4'h6, 8'h50);
      rd(4'h6, 8'hf0, 8'h10);
      rd(4'ha, 8'hff, 8'h00);
      rd(4'hb, 8'hff, 8'h00);
      wr(4'hc, 8'h13);
      rd(4'hc, 8'hff, 8'h00);
      rd(4'hf, 8'hff, 8'h00);
      $display("test registers done");
      wr(4'h4, 8'h13);
      {cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin} <= 4'b1000;
      cyc(4);
      `CHK({tx_pin_q, rts_n_q, dtr_n_q}, 3'b111)
      rd(4'h6, 8'hf0, 8'h30);
      wr(4'h0, 8'ha5);
      cyc(200);
      rd(4'h5, 8'h01, 8'h01);
      rd(4'h0, 8'hff, 8'ha5);
      wr(4'h4, 8'h00);
      {cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin} <= 4'b0111;
      $display("test loopback done");
      fork
         wr(4'h0, 8'h55);
         u_peer.recv(1'b0, got);
      join
      `CHK(got, 8'h55)
      u_peer.send(8'h3c, 1'b0, 1'b0);
      cyc(20);
      rd(4'h0, 8'hff, 8'h3c);
      wr(4'h9, 8'h80);
      cts_n_pin <= 1'b1;
      wr(4'h0, 8'h96);
      n = 0;
      repeat (100) @(posedge sys_clk) n += tx_pin_q;
      `CHK(n, 100)
      fork
         cts_n_pin <= 1'b0;
         u_peer.recv(1'b0, got);
      join
      `CHK(got, 8'h96)
      cyc(30);
      wr(4'h9, 8'h00);
      $display("test serial and clear-to-send done");
      wr(4'hb, 8'h01);
      wr(4'h4, 8'h02);
      wr(4'h9, 8'h40);
      cyc(4);
      `CHK(rts_n_q, 1'b0)
      u_peer.send(8'h11, 1'b0, 1'b0);
      cyc(4);
      `CHK(rts_n_q, 1'b1)
      rd(4'h0, 8'hff, 8'h11);
      cyc(4);
      `CHK(rts_n_q, 1'b0)
      wr(4'h9, 8'h00);
      wr(4'h4, 8'h00);
      $display("test request-to-send done");
      wr(4'h8, 8'h10);
      // The idle-high line kept the pulse hold loaded; let it drain so
      // entering infrared mode does not see a false start
      cyc(20);
      wr(4'h4, 8'h40);
      cyc(4);
      `CHK(tx_pin_q, 1'b0)
      u_peer.send(8'hc3, 1'b1, 1'b1);
      cyc(4);
      rd(4'h0, 8'hff, 8'hc3);
      fork
         wr(4'h0, 8'h5a);
         u_peer.recv(1'b1, got);
      join
      `CHK(got, 8'h5a)
      cyc(40);
      fork
         wr(4'h0, 8'h00);
         begin
            cyc(4);
            u_peer.send(8'h81, 1'b1, 1'b1);
         end
      join
      cyc(20);
      rd(4'h5, 8'h01, 8'h00);
      $display("test infrared done");
      close_out;
   end
endmodule
